/* design/page_builder_pkg.sv */
// constants and carrier types for the product data page builder
// assumes one device clock; software loads page content through the register port
`default_nettype none
package page_builder_pkg;

  // ==========================================================
  // register port
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam logic [7:0]  REG_CTRL    = 8'h00;  // start / mode select / status
  localparam logic [7:0]  REG_PAGE    = 8'h04;  // requested page code
  localparam logic [7:0]  REG_ALLOC   = 8'h08;  // allocation length
  localparam logic [7:0]  REG_IFACE   = 8'h0c;  // interface identifier
  localparam logic [7:0]  REG_DEVICE  = 8'h10;  // qualifier, type, savable flag
  localparam logic [7:0]  REG_LENGTHS = 8'h14;  // text and vendor byte counts
  localparam logic [7:0]  REG_CADDR   = 8'h18;  // content pointer
  localparam logic [7:0]  REG_CDATA   = 8'h1c;  // content byte, pointer advances on write

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_MODE   = 1;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_DONE   = 1;
  localparam int unsigned STAT_REJECT = 2;
  localparam int unsigned DEV_PS_BIT  = 8;
  localparam int unsigned LEN_VEND_LSB = 8;

  // ==========================================================
  // page codes and layout
  localparam logic [5:0] MODE_PERIPH_CODE = 6'h09;
  localparam logic [7:0] VPD_SUPPORTED    = 8'h00;
  localparam logic [7:0] VPD_ASCII_LO     = 8'h01;
  localparam logic [7:0] VPD_ASCII_HI     = 8'h7f;
  localparam logic [7:0] VPD_SERIAL       = 8'h80;
  localparam logic [7:0] VPD_OPDEF        = 8'h81;
  localparam logic [7:0] VPD_ASCII_OPDEF  = 8'h82;
  localparam logic [7:0] MODE_HDR_BYTES   = 8'h08;  // vendor data starts here
  localparam logic [7:0] VPD_HDR_BYTES    = 8'h04;
  localparam logic [7:0] ASCII_HDR_BYTES  = 8'h05;  // text starts here
  localparam logic [7:0] SUPPORTED_COUNT  = 8'h03;
  localparam logic [7:0] MODE_LEN_ADJ     = 8'h02;  // length = last index - 1
  localparam logic [7:0] VPD_LEN_ADJ      = 8'h04;  // length = last index - 3
  localparam logic [7:0] BYTE_0 = 8'h00;
  localparam logic [7:0] BYTE_1 = 8'h01;
  localparam logic [7:0] BYTE_2 = 8'h02;
  localparam logic [7:0] BYTE_3 = 8'h03;
  localparam logic [7:0] BYTE_4 = 8'h04;
  localparam logic [7:0] BYTE_5 = 8'h05;
  localparam logic [7:0] BYTE_6 = 8'h06;
  localparam logic [7:0] CHAR_LO  = 8'h20;
  localparam logic [7:0] CHAR_HI  = 8'h7e;
  localparam logic [7:0] CHAR_NUL = 8'h00;
  localparam logic [7:0] CHAR_SP  = 8'h20;
  localparam logic [15:0] IFACE_SCSI = 16'h0000;

  // ==========================================================
  // storage sizes
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned CONTENT_DEPTH = 64;
  localparam int unsigned CONTENT_AW    = 6;
  localparam int unsigned FIFO_DEPTH    = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {KIND_MODE, KIND_SUPPORTED, KIND_ASCII} page_kind_t;
  typedef enum logic {PH_IDLE, PH_RUN} phase_t;

  typedef struct packed {
    logic                  params_savable_flag;  // mode page byte 0 bit 7
    logic [2:0]            qual;                 // peripheral qualifier
    logic [4:0]            dtype;                // peripheral device type
    logic [15:0]           iface;                // interface identifier
    logic [CONTENT_AW-1:0] text_len;             // description / ascii bytes
    logic [CONTENT_AW-1:0] vend_len;             // vendor bytes after text
  } dev_cfg_t;

endpackage : page_builder_pkg
`default_nettype wire

/* design/product_data_page_builder.sv */
// page builder top and its output fifo
// assumes the data-in consumer runs on clk_i and applies back-pressure with ready
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// shift fifo: head word always sits in a flip-flop
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;    // mem[0] is the head
    logic [CW-1:0]               count;  // words held
    logic                        valid;  // head present
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t next_r;

  assign in_ready_o  = (r.count != FULL);  // honest full
  assign out_valid_o = r.valid;
  assign out_data_o  = r.mem[0];

  // pop shifts down, push lands behind the last word
  always_comb begin
    logic          pop;
    logic          push;
    logic [CW-1:0] tmp;
    pop    = r.valid && out_ready_i;
    push   = in_valid_i && in_ready_o;
    tmp    = r.count - CW'(pop);  // words left after the pop
    next_r = r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_r.mem[i] = r.mem[i+1];
      end
    end
    if (push) begin
      next_r.mem[tmp] = in_data_i;
    end
    next_r.count = tmp + CW'(push);
    next_r.valid = (next_r.count != '0);
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : byte_fifo

// ============================================================
// page builder
module product_data_page_builder (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             data_valid_o,
  input  wire logic        data_ready_i,
  output logic [7:0]       data_o,
  output logic             busy_o
);
  typedef struct packed {
    page_builder_pkg::phase_t     phase;   // idle or streaming
    page_builder_pkg::page_kind_t kind;    // page being built
    page_builder_pkg::dev_cfg_t   cfg;     // software-set page fields
    logic [7:0]                   page;    // requested page code
    logic [7:0]                   alloc;   // allocation length
    logic [7:0]                   idx;     // next byte index
    logic [7:0]                   limit;   // bytes to send
    logic [7:0]                   total;   // full page size
    logic                         done;    // last run finished
    logic                         reject;  // last start refused
    logic [page_builder_pkg::CONTENT_AW-1:0] caddr;  // content pointer
    logic [page_builder_pkg::CONTENT_DEPTH-1:0][7:0] mem;  // text + vendor bytes
    logic [31:0]                  rdata;   // read answer
    logic                         busy;    // mirrors phase for the port
  } st_t;

  st_t        r;
  st_t        next_r;
  logic       fifo_ready;  // fifo can take a byte
  logic       push;        // byte enters the fifo
  logic [7:0] push_data;   // byte at r.idx

  // full size of a page; header lengths derive from it
  function automatic logic [7:0] page_total(input page_builder_pkg::page_kind_t k,
                                            input page_builder_pkg::dev_cfg_t c);
    unique case (k)
      page_builder_pkg::KIND_MODE:
        page_total = page_builder_pkg::MODE_HDR_BYTES + 8'(c.vend_len);
      page_builder_pkg::KIND_SUPPORTED:
        page_total = page_builder_pkg::VPD_HDR_BYTES + page_builder_pkg::SUPPORTED_COUNT;
      page_builder_pkg::KIND_ASCII:
        page_total = page_builder_pkg::ASCII_HDR_BYTES + 8'(c.text_len) + 8'(c.vend_len);
      default:
        page_total = '0;  // illegal kind code
    endcase
  endfunction : page_total

  // text byte cleaned to printable codes, last one forced to nul
  function automatic logic [7:0] clean_char(input logic [7:0] ch, input logic last);
    if (last) begin
      clean_char = page_builder_pkg::CHAR_NUL;
    end else if (ch == page_builder_pkg::CHAR_NUL) begin
      clean_char = ch;  // inner line terminator
    end else if (ch < page_builder_pkg::CHAR_LO || ch > page_builder_pkg::CHAR_HI) begin
      clean_char = page_builder_pkg::CHAR_SP;
    end else begin
      clean_char = ch;
    end
  endfunction : clean_char

  // ==========================================================
  // byte generator for the current index
  always_comb begin
    logic [7:0] ci;
    logic [7:0] tl;
    push_data = '0;
    ci = '0;
    tl = 8'(r.cfg.text_len);
    unique case (r.kind)
      page_builder_pkg::KIND_MODE: begin
        ci = r.idx - page_builder_pkg::MODE_HDR_BYTES;
        if (r.idx == page_builder_pkg::BYTE_0) begin
          push_data = {r.cfg.params_savable_flag, 1'b0, page_builder_pkg::MODE_PERIPH_CODE};
        end else if (r.idx == page_builder_pkg::BYTE_1) begin
          push_data = r.total - page_builder_pkg::MODE_LEN_ADJ;
        end else if (r.idx == page_builder_pkg::BYTE_2) begin
          push_data = r.cfg.iface[15:8];
        end else if (r.idx == page_builder_pkg::BYTE_3) begin
          push_data = r.cfg.iface[7:0];
        end else if (r.idx >= page_builder_pkg::MODE_HDR_BYTES) begin
          push_data = r.mem[ci[page_builder_pkg::CONTENT_AW-1:0]];
        end
      end
      page_builder_pkg::KIND_SUPPORTED, page_builder_pkg::KIND_ASCII: begin
        ci = r.idx - page_builder_pkg::ASCII_HDR_BYTES;
        if (r.idx == page_builder_pkg::BYTE_0) begin
          push_data = {r.cfg.qual, r.cfg.dtype};
        end else if (r.idx == page_builder_pkg::BYTE_1) begin
          push_data = r.page;
        end else if (r.idx == page_builder_pkg::BYTE_3) begin
          push_data = r.total - page_builder_pkg::VPD_LEN_ADJ;
        end else if (r.kind == page_builder_pkg::KIND_SUPPORTED) begin
          // ascending list of codes served here
          if (r.idx == page_builder_pkg::BYTE_4) begin
            push_data = page_builder_pkg::VPD_SUPPORTED;
          end else if (r.idx == page_builder_pkg::BYTE_5) begin
            push_data = page_builder_pkg::VPD_ASCII_LO;
          end else if (r.idx == page_builder_pkg::BYTE_6) begin
            push_data = page_builder_pkg::VPD_ASCII_OPDEF;
          end
        end else if (r.idx == page_builder_pkg::BYTE_4) begin
          push_data = tl;
        end else if (ci < tl) begin
          push_data = clean_char(r.mem[ci[page_builder_pkg::CONTENT_AW-1:0]], ci == tl - 8'h01);
        end else if (r.idx >= page_builder_pkg::ASCII_HDR_BYTES) begin
          push_data = r.mem[ci[page_builder_pkg::CONTENT_AW-1:0]];
        end
      end
      default: ;  // illegal kind code sends zero
    endcase
  end

  assign push = (r.phase == page_builder_pkg::PH_RUN) && fifo_ready;

  // ==========================================================
  // register port, start decode and streaming sequence
  always_comb begin
    logic       go;
    logic       ok;
    page_builder_pkg::page_kind_t k;
    go     = '0;
    ok     = '0;
    k      = page_builder_pkg::KIND_MODE;
    next_r = r;
    next_r.rdata = '0;  // unmapped reads give zero
    // writes
    if (wr_i) begin
      unique case (addr_i)
        page_builder_pkg::REG_CTRL:    go = wdata_i[page_builder_pkg::CTRL_START];
        page_builder_pkg::REG_PAGE:    next_r.page = wdata_i[7:0];
        page_builder_pkg::REG_ALLOC:   next_r.alloc = wdata_i[7:0];
        page_builder_pkg::REG_IFACE:   next_r.cfg.iface = wdata_i[15:0];
        page_builder_pkg::REG_DEVICE: begin
          next_r.cfg.qual  = wdata_i[7:5];
          next_r.cfg.dtype = wdata_i[4:0];
          next_r.cfg.params_savable_flag = wdata_i[page_builder_pkg::DEV_PS_BIT];
        end
        page_builder_pkg::REG_LENGTHS: begin
          next_r.cfg.text_len = wdata_i[page_builder_pkg::CONTENT_AW-1:0];
          next_r.cfg.vend_len = wdata_i[page_builder_pkg::LEN_VEND_LSB +: page_builder_pkg::CONTENT_AW];
        end
        page_builder_pkg::REG_CADDR:   next_r.caddr = wdata_i[page_builder_pkg::CONTENT_AW-1:0];
        page_builder_pkg::REG_CDATA: begin
          next_r.mem[r.caddr] = wdata_i[7:0];
          next_r.caddr = r.caddr + page_builder_pkg::CONTENT_AW'(1);
        end
        default: ;  // unmapped write ignored
      endcase
    end
    // reads
    if (rd_i) begin
      unique case (addr_i)
        page_builder_pkg::REG_CTRL: begin
          next_r.rdata[page_builder_pkg::STAT_BUSY]   = (r.phase == page_builder_pkg::PH_RUN);
          next_r.rdata[page_builder_pkg::STAT_DONE]   = r.done;
          next_r.rdata[page_builder_pkg::STAT_REJECT] = r.reject;
        end
        page_builder_pkg::REG_PAGE:    next_r.rdata[7:0] = r.page;
        page_builder_pkg::REG_ALLOC:   next_r.rdata[7:0] = r.alloc;
        page_builder_pkg::REG_IFACE:   next_r.rdata[15:0] = r.cfg.iface;
        page_builder_pkg::REG_DEVICE:  next_r.rdata[8:0] = {r.cfg.params_savable_flag, r.cfg.qual, r.cfg.dtype};
        page_builder_pkg::REG_LENGTHS: begin
          next_r.rdata[page_builder_pkg::CONTENT_AW-1:0] = r.cfg.text_len;
          next_r.rdata[page_builder_pkg::LEN_VEND_LSB +: page_builder_pkg::CONTENT_AW] = r.cfg.vend_len;
        end
        page_builder_pkg::REG_CADDR:   next_r.rdata[page_builder_pkg::CONTENT_AW-1:0] = r.caddr;
        page_builder_pkg::REG_CDATA:   next_r.rdata[7:0] = r.mem[r.caddr];
        default: ;  // zero answer
      endcase
    end
    // classify the request; only codes with a builder are accepted
    if (wdata_i[page_builder_pkg::CTRL_MODE]) begin
      ok = 1'b1;
      k  = page_builder_pkg::KIND_MODE;
    end else if (r.page == page_builder_pkg::VPD_SUPPORTED) begin
      ok = 1'b1;
      k  = page_builder_pkg::KIND_SUPPORTED;
    end else if ((r.page >= page_builder_pkg::VPD_ASCII_LO && r.page <= page_builder_pkg::VPD_ASCII_HI)
                 || r.page == page_builder_pkg::VPD_ASCII_OPDEF) begin
      ok = 1'b1;
      k  = page_builder_pkg::KIND_ASCII;
    end
    unique case (r.phase)
      page_builder_pkg::PH_IDLE: begin
        if (go) begin
          next_r.done   = 1'b0;
          next_r.reject = !ok;
          if (ok) begin
            next_r.kind  = k;
            next_r.idx   = '0;
            next_r.total = page_total(k, r.cfg);
            next_r.limit = (r.alloc < page_total(k, r.cfg)) ? r.alloc : page_total(k, r.cfg);
            if (next_r.limit == '0) begin
              next_r.done = 1'b1;
            end else begin
              next_r.phase = page_builder_pkg::PH_RUN;
            end
          end
        end
      end
      page_builder_pkg::PH_RUN: begin
        // one byte per accepted slot, in ascending order
        if (push) begin
          next_r.idx = r.idx + 8'h01;
          if (r.idx + 8'h01 == r.limit) begin
            next_r.phase = page_builder_pkg::PH_IDLE;
            next_r.done  = 1'b1;
          end
        end
      end
    endcase
    next_r.busy = (next_r.phase == page_builder_pkg::PH_RUN);
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.cfg.iface <= page_builder_pkg::IFACE_SCSI;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;
  assign busy_o  = r.busy;

  // output buffer toward the data-in path
  byte_fifo #(
    .WIDTH (page_builder_pkg::BYTE_W),
    .DEPTH (page_builder_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_data),
    .out_valid_o (data_valid_o),
    .out_ready_i (data_ready_i),
    .out_data_o  (data_o)
  );

  // ==========================================================
  // checks
  logic is_mode;
  logic is_ascii;
  assign is_mode  = (r.kind == page_builder_pkg::KIND_MODE);
  assign is_ascii = (r.kind == page_builder_pkg::KIND_ASCII);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_mode_header_byte: assert property (push && is_mode && r.idx == 8'h00 |->
    push_data == {r.cfg.params_savable_flag, 2'b00, 5'h09}) else $error("mode byte 0 wrong");
  a_mode_length_byte: assert property (push && is_mode && r.idx == 8'h01 |->
    push_data == 8'(r.cfg.vend_len) + 8'h06) else $error("mode page length wrong");
  a_iface_msb_first: assert property (push && is_mode && r.idx == 8'h02 ##1 push |->
    $past(push_data) == r.cfg.iface[15:8] && push_data == r.cfg.iface[7:0]) else $error("iface order wrong");
  a_mode_reserved_zero: assert property (push && is_mode && r.idx >= 8'h04 && r.idx < 8'h08 |->
    push_data == 8'h00) else $error("reserved byte not zero");
  a_vpd_header_length: assert property (push && !is_mode && r.idx == 8'h03 |->
    push_data == (is_ascii ? 8'(r.cfg.text_len) + 8'(r.cfg.vend_len) + 8'h01 : 8'h03) && r.total >= r.limit)
    else $error("vpd length wrong");
  a_desc_length_full: assert property (push && is_ascii && r.idx == 8'h04 |->
    push_data == 8'(r.cfg.text_len)) else $error("description length truncated");
  a_text_printable: assert property (push && is_ascii && r.idx >= 8'h05 && r.idx < 8'h05 + 8'(r.cfg.text_len) |->
    push_data == 8'h00 || (push_data >= 8'h20 && push_data <= 8'h7e)) else $error("text byte not printable");
  a_stop_at_limit: assert property (push && r.idx + 8'h01 == r.limit |=>
    r.phase == page_builder_pkg::PH_IDLE && r.done && !push) else $error("stream did not stop");
  a_reject_code: assert property (wr_i && addr_i == 8'h00 && wdata_i[1:0] == 2'b01 && r.page == 8'h80 &&
    r.phase == page_builder_pkg::PH_IDLE |=> r.reject && r.phase == page_builder_pkg::PH_IDLE) else $error("bad code taken");

  c_mode_done: cover property (push && is_mode && r.idx + 8'h01 == r.limit);
  c_ascii_truncated: cover property (push && is_ascii && r.limit < r.total && r.idx + 8'h01 == r.limit);
  c_fifo_stall: cover property (r.phase == page_builder_pkg::PH_RUN && !fifo_ready);
  c_rejected: cover property (r.reject);
endmodule : product_data_page_builder

`default_nettype wire

/* tb/initiator_model.sv */
// data-in consumer standing in for the initiator
// assumes it shares clk_i with the page builder
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clear_i,       // forget earlier bytes
  input  wire logic [1:0] pace_i,        // 0 eager, 1 random, 2 stopped
  input  wire logic       data_valid_i,
  input  wire logic [7:0] data_i,
  output logic            data_ready_o
);
  logic [7:0]  rx [0:255];  // bytes taken, in arrival order
  int          rx_count;    // bytes taken since clear
  logic [15:0] lfsr;        // pattern for random pacing
  // ==========================================================
  // take a byte at each edge that sees valid and ready together
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_count     <= 0;
      lfsr         <= 16'hace1;
      data_ready_o <= 1'b0;
    end else begin
      lfsr         <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      data_ready_o <= (pace_i == 2'd0) || (pace_i == 2'd1 && lfsr[0]);
      if (clear_i) begin
        rx_count <= 0;
      end else if (data_valid_i && data_ready_o) begin
        rx[rx_count[7:0]] <= data_i;
        rx_count          <= rx_count + 1;
      end
    end
  end
endmodule : initiator_model
`default_nettype wire

/* tb/product_data_page_builder_bench.sv */
// self-checking bench for the page builder
// assumes the initiator model sits on the data-in side
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module product_data_page_builder_bench;
  logic clk_i, reset_n_i, wr_i, rd_i, clear, data_valid_o, data_ready_i, busy_o;
  logic [7:0]  addr_i, data_o, ps, qual, dtype;
  logic [31:0] wdata_i, rdata_o, r;
  logic [1:0]  pace;
  logic [15:0] iface;
  logic [7:0]  mem [64];   // mirror of content memory
  int          errors, comparisons, tl, vl, i, seed;
  logic [15:0] ids [5] = '{16'h0000, 16'h0004, 16'h7fff, 16'h8000, 16'hffff};
  logic [7:0]  bad [6] = '{8'h80, 8'h81, 8'h83, 8'h8f, 8'hc0, 8'hff};
  product_data_page_builder dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_valid_o(data_valid_o), .data_ready_i(data_ready_i),
    .data_o(data_o), .busy_o(busy_o));
  initiator_model model (.clk_i(clk_i), .reset_n_i(reset_n_i), .clear_i(clear), .pace_i(pace),
    .data_valid_i(data_valid_o), .data_i(data_o), .data_ready_o(data_ready_i));
  // ==========================================================
  // clock, bus tasks, expectations
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic set_cfg();
    wr(page_builder_pkg::REG_DEVICE, {23'h0, ps[0], qual[2:0], dtype[4:0]});
    wr(page_builder_pkg::REG_IFACE, {16'h0, iface});
    wr(page_builder_pkg::REG_LENGTHS, {18'h0, 6'(vl), 2'b0, 6'(tl)});
    rd(page_builder_pkg::REG_DEVICE, r);
    `CHECK(r, {23'h0, ps[0], qual[2:0], dtype[4:0]})
    rd(page_builder_pkg::REG_IFACE, r);
    `CHECK(r, {16'h0, iface})
    rd(page_builder_pkg::REG_LENGTHS, r);
    `CHECK(r, {18'h0, 6'(vl), 2'b0, 6'(tl)})
  endtask : set_cfg
  function automatic logic [7:0] exp_byte(bit mode, logic [7:0] code, int idx, int total);
    int j;
    j = idx - 5;
    if (mode) begin
      case (idx)
        0: return {ps[0], 1'b0, page_builder_pkg::MODE_PERIPH_CODE};
        1: return 8'(total - 2);
        2: return iface[15:8];
        3: return iface[7:0];
        4, 5, 6, 7: return 8'h00;
        default: return mem[idx - 8];
      endcase
    end
    case (idx)
      0: return {qual[2:0], dtype[4:0]};
      1: return code;
      2: return 8'h00;
      3: return 8'(total - 4);
      4: return (code == 8'h00) ? 8'h00 : 8'(tl);
      default: ;
    endcase
    if (code == 8'h00) return (idx == 5) ? 8'h01 : 8'h82;
    if (j >= tl) return mem[j];
    if (j == tl - 1 || mem[j] == 8'h00) return 8'h00;
    if (mem[j] < 8'h20 || mem[j] > 8'h7e) return 8'h20;
    return mem[j];
  endfunction : exp_byte
  // one page request: start, drain, compare every byte and the status
  task automatic run(input bit mode, input logic [7:0] code, input logic [7:0] alloc, input logic [1:0] pc);
    int total, lim, n;
    bit rej;
    total = mode ? 8 + vl : (code == 8'h00) ? 7 : 5 + tl + vl;
    rej = !mode && !(code <= 8'h7f || code == 8'h82);
    lim = rej ? 0 : (alloc < total) ? alloc : total;
    @(posedge clk_i);
    clear <= 1'b1;
    pace <= pc;
    @(posedge clk_i);
    clear <= 1'b0;
    wr(page_builder_pkg::REG_PAGE, {24'h0, code});
    wr(page_builder_pkg::REG_ALLOC, {24'h0, alloc});
    rd(page_builder_pkg::REG_PAGE, r);
    `CHECK(r, {24'h0, code})
    rd(page_builder_pkg::REG_ALLOC, r);
    `CHECK(r, {24'h0, alloc})
    wr(page_builder_pkg::REG_CTRL, {30'h0, mode, 1'b1});
    if (pc == 2'd2) begin
      repeat (30) @(posedge clk_i);
      `CHECK(busy_o, 1'b1)
      `CHECK(model.rx_count, 0)
      pace <= 2'd0;
    end
    repeat (2) @(posedge clk_i);
    for (n = 0; n < 3000 && (busy_o !== 1'b0 || data_valid_o !== 1'b0); n++) @(posedge clk_i);
    if (n == 3000) errors++;
    `CHECK(model.rx_count, lim)
    for (n = 0; n < lim; n++) `CHECK(model.rx[n], exp_byte(mode, code, n, total))
    rd(page_builder_pkg::REG_CTRL, r);
    `CHECK(r[2:0], {rej, !rej, 1'b0})
  endtask : run
  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // watchdog and main sequence
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    {addr_i, wdata_i, wr_i, rd_i, clear, pace, reset_n_i, errors, comparisons} = '0;
    seed = 32'hbfc16239;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(page_builder_pkg::REG_CTRL, r);
    `CHECK(r, 32'h0)
    for (i = 0; i < 64; i++) mem[i] = 8'($random(seed));
    mem[2] = 8'h00;  // inner line end
    mem[3] = 8'h7f;  // out-of-range characters
    mem[4] = 8'h1f;
    wr(page_builder_pkg::REG_CADDR, 32'h0);
    for (i = 0; i < 64; i++) wr(page_builder_pkg::REG_CDATA, {24'h0, mem[i]});
    wr(page_builder_pkg::REG_CADDR, 32'h5);
    rd(page_builder_pkg::REG_CDATA, r);
    `CHECK(r[7:0], mem[5])
    rd(page_builder_pkg::REG_CADDR, r);
    `CHECK(r, 32'h5)
    rd(8'h40, r);
    `CHECK(r, 32'h0)
    for (i = 0; i < 5; i++) begin
      {ps, qual, dtype} = 24'($random(seed));
      iface = ids[i];
      tl = 1 + ($random(seed) & 15);
      vl = i * 6;
      set_cfg();
      run(1'b1, 8'h00, 8'hff, 2'd0);
      run(1'b1, 8'h00, 8'(1 + i), 2'd0);
      run(1'b0, 8'h82, 8'hff, 2'd0);
      run(1'b0, 8'h82, 8'(4 + i), 2'd0);
      run(1'b0, 8'h00, 8'(3 + i), 2'd0);
      run(1'b0, 8'(1 + ($random(seed) & 8'h7e)), 8'hff, 2'd1);
      run(1'b0, bad[i], 8'hff, 2'd0);
    end
    run(1'b0, bad[5], 8'hff, 2'd0);
    run(1'b0, 8'h00, 8'hff, 2'd0);
    run(1'b0, 8'h7f, 8'h00, 2'd0);
    tl = 0;
    vl = 9;
    set_cfg();
    run(1'b0, 8'h82, 8'hff, 2'd0);
    run(1'b0, 8'h01, 8'hff, 2'd0);
    vl = 40;
    set_cfg();
    run(1'b1, 8'h00, 8'd30, 2'd2);
    print_verdict();
  end
endmodule : product_data_page_builder_bench
`default_nettype wire
